//--- acc_adc_ctrl.sv
// converter start, busy, done flag, trigger selection and input routing
// assumes same-clock bus strobes; pwm, pin and period events are async
`timescale 1ns/100ps

// Notes on behaviour
// [R1] done flag, bit 7, sets when a conversion finishes
// [R2] no new conversion starts while done flag is 1
// [R3] done flag stays set until software writes it zero
// [R4] writing 1 to bit 6 starts a conversion; writing 0 does nothing
// [R5] busy bit stays 1 during conversion, hardware clears it at completion
// [R6] reading bit 6 reports busy state, not written value
// [R7] source field 5:4 selects pwm 0, pwm 2, pwm 4 or start pin
// [R8] channel field 3:0 selects inputs 0..7 or band-gap; other codes reserved
// [R9] with converter off, all analog inputs are disconnected
// [R10] main control register at E8H, read/write, bit-addressable, resets zero
// [R11] external triggers start conversions only when external trigger allowed
// [R12] condition field picks falling, rising, pwm centre or pwm end event
// [R13] external triggers ignored while busy bit reads 1
// [R14] a 9-bit delay is counted after external trigger before conversion
// [R15] conversion length is a parameter; busy clears and done sets together
module acc_adc_ctrl
   import acc_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   // clock and reset
   input  wire logic               CLK_SYS,
   input  wire logic               SRST,
   // special function register bus
   input  wire logic [7:0]         SFR_ADDR,
   input  wire logic               SFR_WR,
   input  wire logic [7:0]         SFR_WDATA,
   input  wire logic               SFR_BIT_WR,
   input  wire logic [2:0]         SFR_BIT_SEL,
   input  wire logic               SFR_BIT_VAL,
   output logic      [7:0]         SFR_RDATA,
   // settings held in the second control register
   input  wire logic               CONVERTER_POWER_ON,
   input  wire logic               EXT_TRIGGER_ALLOW,
   input  wire logic [1:0]         EXT_TRIGGER_CONDITION_SEL,
   input  wire logic [DELAY_W-1:0] TRIGGER_DELAY_COUNT,
   // trigger sources
   input  wire logic               PWM_CHAN_ZERO,
   input  wire logic               PWM_CHAN_TWO,
   input  wire logic               PWM_CHAN_FOUR,
   input  wire logic               EXT_START_PIN,
   input  wire logic               PWM_CENTRE_EVT,
   input  wire logic               PWM_END_EVT,
   // analog core
   output logic                    CONV_START,
   output logic [8:0]              INPUT_ROUTE,
   output logic                    CONV_DONE
);

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   logic [5:0] raw_in;
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] sync3_q;

   assign raw_in = {PWM_END_EVT, PWM_CENTRE_EVT, EXT_START_PIN,
                    PWM_CHAN_FOUR, PWM_CHAN_TWO, PWM_CHAN_ZERO};

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
         sync3_q <= 6'h00;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // -----------------------------------------------------------------
   // edge detect settling
   // -----------------------------------------------------------------
   // history is cleared by reset, so a pin idling high would look like an edge
   logic [1:0] prime_q;
   logic       armed;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         prime_q <= 2'h0;
      end else if (prime_q != 2'h3) begin
         prime_q <= prime_q + 2'h1;
      end
   end

   assign armed = (prime_q == 2'h3);

   // -----------------------------------------------------------------
   // register state
   // -----------------------------------------------------------------
   logic                done_q;
   logic                busy_q;
   logic [1:0]          src_q;
   logic [3:0]          chan_q;
   acc_state_t          state_q;
   logic [DELAY_W-1:0]  dly_q;
   logic [15:0]         conv_q;

   // -----------------------------------------------------------------
   // write decode, whole byte or single bit
   // -----------------------------------------------------------------
   logic       hit;
   logic [7:0] wmask;
   logic [7:0] wval;

   always_comb begin
      hit   = (SFR_ADDR == MAIN_CTRL_ADDR) && (SFR_WR || SFR_BIT_WR); // R10
      wmask = 8'h00;
      wval  = 8'h00;
      if (SFR_WR) begin
         wmask = 8'hFF;
         wval  = SFR_WDATA;
      end else if (SFR_BIT_WR) begin
         wmask = 8'h01 << SFR_BIT_SEL;
         wval  = {8{SFR_BIT_VAL}} & wmask;
      end
   end

   // -----------------------------------------------------------------
   // trigger selection and detection
   // -----------------------------------------------------------------
   logic src_now;
   logic src_old;
   logic ext_evt;

   always_comb begin
      case (src_q) // R7
         SRC_PWM_CHAN_ZERO: begin
            src_now = sync2_q[0];
            src_old = sync3_q[0];
         end
         SRC_PWM_CHAN_TWO: begin
            src_now = sync2_q[1];
            src_old = sync3_q[1];
         end
         SRC_PWM_CHAN_FOUR: begin
            src_now = sync2_q[2];
            src_old = sync3_q[2];
         end
         default: begin
            src_now = sync2_q[3];
            src_old = sync3_q[3];
         end
      endcase
      case (EXT_TRIGGER_CONDITION_SEL) // R12
         COND_FALL:   ext_evt = src_old && !src_now;
         COND_RISE:   ext_evt = !src_old && src_now;
         COND_CENTRE: ext_evt = sync2_q[4] && !sync3_q[4];
         default:     ext_evt = sync2_q[5] && !sync3_q[5];
      endcase
   end

   logic sw_start;
   logic sw_go;
   logic ext_ok;
   logic ext_take;
   logic dly_last;
   logic launch;
   logic conv_end;

   // a written 0 on the start bit is simply dropped
   assign sw_start = hit && wmask[BUSY_BIT] && wval[BUSY_BIT]; // R4
   assign sw_go    = sw_start && !done_q && (state_q == ST_IDLE); // R2
   assign ext_ok   = EXT_TRIGGER_ALLOW && armed && ext_evt; // R11
   assign ext_take = ext_ok && !busy_q && !done_q && (state_q == ST_IDLE); // R13 R2
   assign dly_last = (state_q == ST_DELAY) && (dly_q == DELAY_W'(1)); // R14
   assign launch   = sw_go || (ext_take && TRIGGER_DELAY_COUNT == '0) || dly_last;
   assign conv_end = (state_q == ST_CONV) && (conv_q == 16'(CONV_LEN - 1)); // R15

   // -----------------------------------------------------------------
   // conversion sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (sw_go) begin // R2
                  state_q <= ST_CONV;
               end else if (ext_take) begin
                  state_q <= (TRIGGER_DELAY_COUNT == '0) ? ST_CONV : ST_DELAY; // R14
               end
            end
            ST_DELAY: begin
               if (dly_last) begin
                  state_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_end) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // delay counter, loaded when an external trigger is taken
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         dly_q <= '0;
      end else if (ext_take && !sw_go) begin
         dly_q <= TRIGGER_DELAY_COUNT; // R14
      end else if (state_q == ST_DELAY) begin
         dly_q <= dly_q - DELAY_W'(1); // R14
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         conv_q <= 16'h0000;
      end else if (state_q == ST_CONV) begin
         conv_q <= conv_q + 16'h0001; // R15
      end else begin
         conv_q <= 16'h0000;
      end
   end

   // -----------------------------------------------------------------
   // busy and done flags
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         busy_q <= 1'b0;
      end else if (conv_end) begin
         busy_q <= 1'b0; // R5 R15
      end else if (sw_go || ext_take) begin
         busy_q <= 1'b1; // R5 R13
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         done_q <= MAIN_CTRL_RESET[DONE_BIT];
      end else if (conv_end) begin
         done_q <= 1'b1; // R1 R15
      end else if (hit && wmask[DONE_BIT]) begin
         done_q <= wval[DONE_BIT]; // R3
      end
   end

   // -----------------------------------------------------------------
   // source and channel fields
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         src_q  <= MAIN_CTRL_RESET[SRC_HI:SRC_LO];
         chan_q <= MAIN_CTRL_RESET[CHAN_HI:CHAN_LO];
      end else if (hit) begin
         src_q  <= (src_q & ~wmask[SRC_HI:SRC_LO]) | wval[SRC_HI:SRC_LO];
         chan_q <= (chan_q & ~wmask[CHAN_HI:CHAN_LO]) | wval[CHAN_HI:CHAN_LO];
      end
   end

   // -----------------------------------------------------------------
   // read data, one cycle behind the address
   // -----------------------------------------------------------------
   logic [7:0] rd_word;

   assign rd_word = {done_q, busy_q, src_q, chan_q}; // R6

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_ADDR == MAIN_CTRL_ADDR) begin
         SFR_RDATA <= rd_word; // R6 R10
      end else begin
         SFR_RDATA <= 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // converter core strobes
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         CONV_START <= 1'b0;
      end else begin
         CONV_START <= launch; // R4 R11 R14
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         CONV_DONE <= 1'b0;
      end else begin
         CONV_DONE <= conv_end; // R1
      end
   end

   // -----------------------------------------------------------------
   // analog input routing
   // -----------------------------------------------------------------
   logic [8:0] route_d;

   always_comb begin
      route_d = 9'h000;
      if (CONVERTER_POWER_ON && chan_q <= CHAN_BANDGAP) begin // R9
         route_d = 9'h001 << chan_q; // R8
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         INPUT_ROUTE <= 9'h000;
      end else begin
         INPUT_ROUTE <= route_d;
      end
   end

endmodule // acc_adc_ctrl

//--- acc_pkg.sv
// constants for the converter start/trigger control block
// assumes an 8-bit special function register bus on the system clock
package acc_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] MAIN_CTRL_ADDR  = 8'hE8;
   localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
   localparam int         DONE_BIT        = 7;
   localparam int         BUSY_BIT        = 6;
   localparam int         SRC_HI          = 5;
   localparam int         SRC_LO          = 4;
   localparam int         CHAN_HI         = 3;
   localparam int         CHAN_LO         = 0;

   // -----------------------------------------------------------------
   // encodings and timing
   // -----------------------------------------------------------------
   localparam logic [1:0] SRC_PWM_CHAN_ZERO        = 2'h0;
   localparam logic [1:0] SRC_PWM_CHAN_TWO        = 2'h1;
   localparam logic [1:0] SRC_PWM_CHAN_FOUR        = 2'h2;
   localparam logic [1:0] SRC_PIN         = 2'h3;
   localparam logic [1:0] COND_FALL       = 2'h0;
   localparam logic [1:0] COND_RISE       = 2'h1;
   localparam logic [1:0] COND_CENTRE     = 2'h2;
   localparam logic [1:0] COND_END        = 2'h3;
   localparam logic [3:0] CHAN_LAST_AIN   = 4'h7;
   localparam logic [3:0] CHAN_BANDGAP    = 4'h8;
   localparam int         DELAY_W         = 9;
   localparam int         CONV_CYCLES     = 16;

   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} acc_state_t;

endpackage

//--- acc_adc_ctrl_props.sv
// port checker for the converter start and trigger control block
// assumes it is bound onto acc_adc_ctrl, one clock domain
`timescale 1ns/100ps
module acc_adc_ctrl_props
   import acc_pkg::*;
#(parameter int CONV_LEN = CONV_CYCLES) (
   input wire logic       CLK_SYS,
   input wire logic       SRST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic       SFR_BIT_WR,
   input wire logic [2:0] SFR_BIT_SEL,
   input wire logic       SFR_BIT_VAL,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       CONVERTER_POWER_ON,
   input wire logic       CONV_START,
   input wire logic [8:0] INPUT_ROUTE,
   input wire logic       CONV_DONE
);
   localparam int LO = CONV_LEN - 1;
   localparam int HI = CONV_LEN + 1;
   logic [15:0] cnt_q;
   logic        pend_q;
   logic        flag_q;
   logic        clr;
   // software write that clears the done flag
   assign clr = SFR_ADDR == MAIN_CTRL_ADDR && (SFR_WR ? !SFR_WDATA[7] :
                SFR_BIT_WR && SFR_BIT_SEL == 3'h7 && !SFR_BIT_VAL);
   always_ff @(posedge CLK_SYS) begin
      cnt_q  <= CONV_START ? 16'h0001 : cnt_q + 16'h0001;
      pend_q <= !SRST && (CONV_START || (pend_q && !CONV_DONE));
      flag_q <= !SRST && (CONV_DONE || (flag_q && !clr));
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   reset_quiet_a: assert property ($fell(SRST) |->
      SFR_RDATA == 8'h00 && !CONV_START && !CONV_DONE) else $error("busy after reset");
   unmapped_read_a: assert property (SFR_ADDR != MAIN_CTRL_ADDR |=>
      SFR_RDATA == 8'h00) else $error("unmapped read not zero");
   power_off_a: assert property (!CONVERTER_POWER_ON |=> INPUT_ROUTE == 9'h000)
      else $error("input routed while off");
   route_onehot_a: assert property ($onehot0(INPUT_ROUTE)) else $error("route not one-hot");
   start_pulse_a: assert property (CONV_START |=> !CONV_START) else $error("start too long");
   done_pulse_a: assert property (CONV_DONE |=> !CONV_DONE) else $error("done too long");
   conv_time_a: assert property (CONV_DONE |-> cnt_q >= LO && cnt_q <= HI)
      else $error("done at wrong time");
   conv_bound_a: assert property (CONV_START |-> ##[LO:HI] CONV_DONE)
      else $error("conversion never ends");
   no_overlap_a: assert property (CONV_START |-> !pend_q) else $error("start while busy");
   done_block_a: assert property (CONV_START |-> !flag_q) else $error("start while done");
   cover property (CONV_START);
   cover property (CONV_DONE);
   cover property (!CONVERTER_POWER_ON ##1 CONVERTER_POWER_ON);
endmodule // acc_adc_ctrl_props
bind acc_adc_ctrl acc_adc_ctrl_props #(.CONV_LEN(CONV_LEN)) u_props (.CLK_SYS, .SRST,
   .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_BIT_WR, .SFR_BIT_SEL, .SFR_BIT_VAL, .SFR_RDATA,
   .CONVERTER_POWER_ON, .CONV_START, .INPUT_ROUTE, .CONV_DONE);

//--- acc_cpu_model.sv
// processor core model: byte, bit and read cycles on the register bus
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/100ps
module acc_cpu_model (
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic            wr,
   output logic      [7:0] wdata,
   output logic            bit_wr,
   output logic      [2:0] bit_sel,
   output logic            bit_val
);
   initial {addr, wr, wdata, bit_wr, bit_sel, bit_val} = '0;
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic wrb(input logic [2:0] s, input logic v);
      @(posedge clk);
      addr    <= 8'hE8;
      bit_sel <= s;
      bit_val <= v;
      bit_wr  <= 1'b1;
      @(posedge clk);
      bit_wr  <= 1'b0;
   endtask
   // read data is registered a cycle behind the address, taken at the edge after
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      @(posedge clk);
      d = rdata;
   endtask
endmodule // acc_cpu_model

//--- acc_adc_ctrl_tb.sv
// testbench for the converter start and trigger control block
// assumes acc_cpu_model as bus master and the bound port checker
`timescale 1ns/100ps
module acc_adc_ctrl_tb
   import acc_pkg::*;
;
   logic clk = 0, rst = 1, pwr = 0, allow = 0;
   logic [1:0] cnd = 2'h0;
   logic [8:0] dly = 9'h008, route;
   logic [5:0] ev = 6'h00;
   logic [7:0] addr, wd, rdata;
   logic wr, bw, bv, cs, cd;
   logic [2:0] bs;
   int fail_count = 0, num_checks = 0, n_start = 0, n_done = 0;
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      n_start <= n_start + int'(cs);
      n_done  <= n_done + int'(cd);
   end
   acc_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .wdata(wd),
      .bit_wr(bw), .bit_sel(bs), .bit_val(bv));
   acc_adc_ctrl #(.CONV_LEN(8)) uut (.CLK_SYS(clk), .SRST(rst), .SFR_ADDR(addr),
      .SFR_WR(wr), .SFR_WDATA(wd), .SFR_BIT_WR(bw), .SFR_BIT_SEL(bs), .SFR_BIT_VAL(bv),
      .SFR_RDATA(rdata), .CONVERTER_POWER_ON(pwr), .EXT_TRIGGER_ALLOW(allow),
      .EXT_TRIGGER_CONDITION_SEL(cnd), .TRIGGER_DELAY_COUNT(dly), .PWM_CHAN_ZERO(ev[0]),
      .PWM_CHAN_TWO(ev[1]), .PWM_CHAN_FOUR(ev[2]), .EXT_START_PIN(ev[3]),
      .PWM_CENTRE_EVT(ev[4]), .PWM_END_EVT(ev[5]), .CONV_START(cs), .INPUT_ROUTE(route),
      .CONV_DONE(cd));
   task automatic chk(input logic [8:0] e, input logic [8:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      cpu.rd8(a, r);
      chk({1'b0, e}, {1'b0, r});
   endtask
   // waits for the start or done counter to move past b, at most 60 cycles
   task automatic wt(input bit dn, input int b, output int k);
      for (k = 0; k < 60 && (dn ? n_done : n_start) == b; k++) @(posedge clk);
   endtask
   task automatic t_sw;
      int b, n;
      pwr <= 1'b1;
      b = n_done;
      cpu.wr8(8'hE8, 8'h45);
      rc(8'hE8, 8'h45);
      wt(1, b, n);
      chk(9'h000, 9'(n_done == b));
      rc(8'hE8, 8'h85);
      b = n_start;
      cpu.wrb(3'h6, 1'b1);
      rc(8'hE8, 8'h85);
      chk(9'h000, 9'(n_start != b));
      cpu.wrb(3'h7, 1'b0);
      rc(8'hE8, 8'h05);
      cpu.wrb(3'h6, 1'b0);
      rc(8'hE8, 8'h05);
      chk(9'h000, 9'(n_start != b));
   endtask
   task automatic t_chan;
      for (int c = 0; c < 17; c++) begin
         pwr <= c < 16;
         cpu.wr8(8'hE8, 8'(c % 16));
         repeat (2) @(posedge clk);
         chk(c < 9 ? 9'h001 << c : 9'h000, route);
      end
   endtask
   task automatic ext(input logic [1:0] s, c, input int k, input logic a, e);
      int n, b;
      cpu.wr8(8'hE8, {2'h0, s, 4'h0});
      cnd <= c;
      ev  <= c == COND_FALL ? 6'h01 << k : 6'h00;
      repeat (6) @(posedge clk);
      b = n_start;
      allow <= a;
      ev    <= c == COND_FALL ? 6'h00 : 6'h01 << k;
      wt(0, b, n);
      chk({8'h00, e}, 9'(n_start != b));
      if (e) begin
         // sync, detect, take and count edges add five to the delay
         chk(dly + 9'h005, 9'(n));
         wt(1, n_done, n);
         cpu.wrb(3'h7, 1'b0);
      end
      allow <= 1'b0;
      ev    <= 6'h00;
   endtask
   // pin edges while busy and while done is set start nothing
   task automatic t_busy;
      int b, n;
      b = n_start;
      cpu.wr8(8'hE8, 8'h70);
      cnd   <= COND_RISE;
      allow <= 1'b1;
      ev    <= 6'h08;
      repeat (4) @(posedge clk);
      ev <= 6'h00;
      wt(1, n_done, n);
      ev <= 6'h08;
      repeat (12) @(posedge clk);
      chk(9'h001, 9'(n_start - b));
      rc(8'hE8, 8'hB0);
      cpu.wrb(3'h7, 1'b0);
      ev    <= 6'h00;
      allow <= 1'b0;
   endtask
   // reset in mid conversion returns the register to zero
   task automatic t_rst;
      cpu.wr8(8'hE8, 8'h78);
      repeat (3) @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc(8'hE8, 8'h00);
      chk(9'h001, route);
   endtask
   task results;
      $display("checks=%0d errors=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc(8'hE8, 8'h00);
      rc(8'hE9, 8'h00);
      t_sw;
      t_chan;
      pwr <= 1'b1;
      for (int i = 0; i < 4; i++) ext(2'(i), i == 3 ? COND_FALL : COND_RISE, i, 1, 1);
      ext(SRC_PWM_CHAN_ZERO, COND_CENTRE, 4, 1, 1);
      ext(SRC_PWM_CHAN_ZERO, COND_END, 5, 1, 1);
      ext(SRC_PWM_CHAN_ZERO, COND_RISE, 1, 1, 0);
      ext(SRC_PIN, COND_RISE, 3, 0, 0);
      t_busy;
      t_rst;
      results;
   end
   initial begin
      #100us;
      fail_count++;
      results;
   end
endmodule // acc_adc_ctrl_tb
